// ### frs_pkg.sv
package frs_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ                  = 10_000_000;
  localparam int unsigned POWER_UP_WAIT_US        = 300;
  localparam int unsigned WARM_RESET_DURATION_US  = 30;
  localparam int unsigned RESET_PULSE_MIN_NS      = 200;
  localparam int unsigned EXTENSION_TICK_US       = 32;
  localparam int unsigned DEEP_SLEEP_WAKE_US      = 300;
  localparam int unsigned POWER_UP_WAIT_CYC       = POWER_UP_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WARM_RESET_CYC          = WARM_RESET_DURATION_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESET_PULSE_CYC         = (RESET_PULSE_MIN_NS * (CLK_HZ / 1_000_000)
                                                     + 999) / 1000;
  localparam int unsigned EXTENSION_TICK_CYC      = EXTENSION_TICK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEEP_SLEEP_WAKE_CYC     = DEEP_SLEEP_WAKE_US * (CLK_HZ / 1_000_000);

  // Register byte offsets
  localparam logic [11:0] EXT_COUNT_OFFSET  = 12'h000;
  localparam logic [11:0] CONTROL_OFFSET    = 12'h004;
  localparam logic [11:0] STATUS_OFFSET     = 12'h008;
  localparam logic [11:0] EXT_LOCK_OFFSET   = 12'h00c;

  // Reset values
  localparam logic [15:0] EXT_COUNT_RESET   = 16'hffff;
  localparam logic [15:0] EXT_COUNT_NONE    = 16'hffff;

  // Control register fields
  localparam int unsigned CTRL_POWER_GOOD_BIT = 0;
  localparam int unsigned CTRL_SLEEP_BIT      = 1;
  localparam int unsigned CTRL_CLR_STATUS_BIT = 2;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB      = 0;
  localparam int unsigned STAT_COLD_DONE_BIT  = 4;
  localparam int unsigned STAT_LOCKED_BIT     = 5;
  localparam int unsigned STAT_PROG_FAIL_BIT  = 6;
  localparam int unsigned STAT_RELOAD_BIT     = 7;

  typedef enum logic [2:0] {
    FRS_OFF     = 3'b000,
    FRS_COLD    = 3'b001,
    FRS_EXTEND  = 3'b010,
    FRS_WARM    = 3'b011,
    FRS_HWRESET = 3'b100,
    FRS_STANDBY = 3'b101,
    FRS_SLEEP   = 3'b110,
    FRS_WAKE    = 3'b111
  } frs_state_e;

  typedef struct packed {
    logic        accept_cmd;
    logic        select_ok;
    logic        outputs_en;
    logic        reload_cfg;
    logic        abort_op;
  } frs_gate_s;

endpackage

// ### flash_reset_sequencer.sv
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Supply good starts cold reset, inputs ignored
// - Cold reset blocks commands, select, outputs
// - Reset low: finish at later of waits
// - Reset low during cold reset never reruns it
// - Reset out low until cold plus extension
// - Extension equals count plus one ticks; an all-ones count gives no extension
// - Extension tick period within 25-42 us
// - Extension count programs only once
// - Interrupt output floats through power-up
// - Hardware reset aborts, floats, clears status
// - Select ignored for warm reset duration
// - Reset low blocks commands and reads
// - Hardware reset reloads bus configuration
// - Later hardware reset runs short warm reset
// - After warm reset follow reset input
// - Reset pulse wakes deep sleep to defaults
module flash_reset_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_in_n,
  input  wire logic        chip_select_n,
  output logic             system_reset_out_n_o,
  output logic             system_reset_out_n_oe_n,
  output logic             int_out_n_oe_n,
  output logic             accept_cmd,
  output logic             select_ok,
  output logic             outputs_en,
  output logic             reload_cfg,
  output logic             abort_op,
  output logic             cs_seen
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic rst_meta_q, rst_sync_q, cs_meta_q, cs_sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
      cs_meta_q  <= 1'b1;
      cs_sync_q  <= 1'b1;
    end
    else
    begin
      rst_meta_q <= reset_in_n;
      rst_sync_q <= rst_meta_q;
      cs_meta_q  <= chip_select_n;
      cs_sync_q  <= cs_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0]             ext_count_q;
  logic                    ext_locked_q;
  logic                    prog_fail_q;
  logic                    power_good_q;
  logic                    sleep_req_q;
  logic                    cold_done_q;
  logic                    reload_seen_q;
  frs_pkg::frs_state_e     state_q, state_d;

  logic wr_en;
  assign wr_en = psel && penable && pready && pwrite;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == frs_pkg::EXT_COUNT_OFFSET) || (a == frs_pkg::CONTROL_OFFSET) ||
                 (a == frs_pkg::STATUS_OFFSET) || (a == frs_pkg::EXT_LOCK_OFFSET);
  endfunction

  // Nonvolatile count: first write sticks, later writes flag a failure
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_count_q  <= frs_pkg::EXT_COUNT_RESET;
      ext_locked_q <= 1'b0;
    end
    else if (wr_en && paddr == frs_pkg::EXT_COUNT_OFFSET && !ext_locked_q)
    begin
      ext_count_q  <= pwdata[15:0];
      ext_locked_q <= 1'b1;
    end
  end

  logic prog_fail_set, status_clr;
  assign prog_fail_set = wr_en && paddr == frs_pkg::EXT_COUNT_OFFSET && ext_locked_q;
  assign status_clr    = wr_en && paddr == frs_pkg::CONTROL_OFFSET &&
                         pwdata[frs_pkg::CTRL_CLR_STATUS_BIT];

  // Set wins over clear; a hardware reset also clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prog_fail_q <= 1'b0;
    else if (prog_fail_set)
      prog_fail_q <= 1'b1;
    else if (status_clr || state_q == frs_pkg::FRS_WARM)
      prog_fail_q <= 1'b0;
  end

  logic sleep_clr;
  assign sleep_clr = (state_q == frs_pkg::FRS_SLEEP) && !rst_sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_good_q <= 1'b0;
      sleep_req_q  <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == frs_pkg::CONTROL_OFFSET)
        power_good_q <= pwdata[frs_pkg::CTRL_POWER_GOOD_BIT];
      if (wr_en && paddr == frs_pkg::CONTROL_OFFSET && pwdata[frs_pkg::CTRL_SLEEP_BIT])
        sleep_req_q <= 1'b1;
      else if (sleep_clr || state_q != frs_pkg::FRS_STANDBY)
        sleep_req_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extension tick and timer
  localparam int unsigned TCW = $clog2(frs_pkg::DEEP_SLEEP_WAKE_CYC + 1);
  localparam int unsigned KW  = $clog2(frs_pkg::EXTENSION_TICK_CYC);

  logic [KW-1:0]  tick_cnt_q;
  logic           tick;
  logic [TCW-1:0] timer_q;
  logic [16:0]    ext_left_q;
  logic [TCW-1:0] rst_low_q;

  // Divider, 32 us per tick; held in cold reset so the extension counts whole ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_q <= '0;
    else if (tick || state_q == frs_pkg::FRS_COLD)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + KW'(1);
  end
  assign tick = (tick_cnt_q == KW'(frs_pkg::EXTENSION_TICK_CYC - 1));

  // Length of time reset input has been low, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_low_q <= '0;
    else if (rst_sync_q)
      rst_low_q <= '0;
    else if (rst_low_q != {TCW{1'b1}})
      rst_low_q <= rst_low_q + TCW'(1);
  end

  logic timer_load;
  logic [TCW-1:0] timer_val;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_q <= '0;
    else if (timer_load)
      timer_q <= timer_val;
    else if (timer_q != '0)
      timer_q <= timer_q - TCW'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_left_q <= '0;
    else if (state_q == frs_pkg::FRS_COLD)
      ext_left_q <= {1'b0, ext_count_q} + 17'h00001;
    else if (state_q == frs_pkg::FRS_EXTEND && tick && ext_left_q != '0)
      ext_left_q <= ext_left_q - 17'h00001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    state_d    = state_q;
    timer_load = 1'b0;
    timer_val  = '0;
    case (state_q)
      frs_pkg::FRS_OFF:
        if (power_good_q)
        begin
          state_d    = frs_pkg::FRS_COLD;
          timer_load = 1'b1;
          timer_val  = TCW'(frs_pkg::POWER_UP_WAIT_CYC);
        end
      frs_pkg::FRS_COLD:
        if (timer_q == '0)
        begin
          // low reset extends to the warm duration after the wait
          if (!rst_sync_q && rst_low_q < TCW'(frs_pkg::WARM_RESET_CYC))
            state_d = frs_pkg::FRS_COLD;
          else if (ext_count_q == frs_pkg::EXT_COUNT_NONE)
            state_d = rst_sync_q ? frs_pkg::FRS_STANDBY : frs_pkg::FRS_HWRESET;
          else
            state_d = frs_pkg::FRS_EXTEND;
        end
      frs_pkg::FRS_EXTEND:
        if (ext_left_q == '0)
          state_d = rst_sync_q ? frs_pkg::FRS_STANDBY : frs_pkg::FRS_HWRESET;
      frs_pkg::FRS_WARM:
        if (timer_q == '0)
          state_d = rst_sync_q ? frs_pkg::FRS_STANDBY : frs_pkg::FRS_HWRESET;
      frs_pkg::FRS_HWRESET:
        if (rst_sync_q)
          state_d = frs_pkg::FRS_STANDBY;
      frs_pkg::FRS_STANDBY:
        if (!rst_sync_q)
        begin
          timer_load = 1'b1;
          if (!cold_done_q)
          begin
            state_d   = frs_pkg::FRS_COLD;
            timer_val = TCW'(frs_pkg::POWER_UP_WAIT_CYC);
          end
          else
          begin
            state_d   = frs_pkg::FRS_WARM;
            timer_val = TCW'(frs_pkg::WARM_RESET_CYC);
          end
        end
        else if (sleep_req_q)
          state_d = frs_pkg::FRS_SLEEP;
      frs_pkg::FRS_SLEEP:
        if (!rst_sync_q && rst_low_q >= TCW'(frs_pkg::RESET_PULSE_CYC - 1))
        begin
          state_d    = frs_pkg::FRS_WAKE;
          timer_load = 1'b1;
          timer_val  = TCW'(frs_pkg::DEEP_SLEEP_WAKE_CYC);
        end
      frs_pkg::FRS_WAKE:
        if (timer_q == '0 && rst_sync_q)
          state_d = frs_pkg::FRS_STANDBY;
      default:
        state_d = frs_pkg::FRS_OFF;
    endcase
    if (!power_good_q)
      state_d = frs_pkg::FRS_OFF;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= frs_pkg::FRS_OFF;
    else
      state_q <= state_d;
  end

  // Cold reset counts as complete once cold or extension is left for any state other than off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cold_done_q <= 1'b0;
    else if (state_q == frs_pkg::FRS_OFF)
      cold_done_q <= 1'b0;
    else if ((state_q == frs_pkg::FRS_COLD || state_q == frs_pkg::FRS_EXTEND) &&
             state_d != state_q && state_d != frs_pkg::FRS_OFF)
      cold_done_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and gate outputs

  frs_pkg::frs_gate_s gate_d;
  logic in_reset;
  assign in_reset = (state_d == frs_pkg::FRS_COLD) || (state_d == frs_pkg::FRS_EXTEND) ||
                    (state_d == frs_pkg::FRS_OFF);

  always_comb
  begin
    gate_d.accept_cmd = (state_d == frs_pkg::FRS_STANDBY) && rst_sync_q;
    gate_d.select_ok  = gate_d.accept_cmd;
    gate_d.outputs_en = gate_d.accept_cmd;
    gate_d.reload_cfg = (state_d == frs_pkg::FRS_WARM) && (state_q != frs_pkg::FRS_WARM);
    gate_d.abort_op   = (state_d == frs_pkg::FRS_WARM) || (state_d == frs_pkg::FRS_HWRESET) ||
                        in_reset;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      system_reset_out_n_o    <= 1'b0;
      system_reset_out_n_oe_n <= 1'b0;
      int_out_n_oe_n          <= 1'b1;
      accept_cmd              <= 1'b0;
      select_ok               <= 1'b0;
      outputs_en              <= 1'b0;
      reload_cfg              <= 1'b0;
      abort_op                <= 1'b1;
      cs_seen                 <= 1'b0;
      reload_seen_q           <= 1'b0;
    end
    else
    begin
      system_reset_out_n_o    <= 1'b0;
      system_reset_out_n_oe_n <= !in_reset;
      int_out_n_oe_n          <= 1'b1;
      accept_cmd              <= gate_d.accept_cmd;
      select_ok               <= gate_d.select_ok;
      outputs_en              <= gate_d.outputs_en;
      reload_cfg              <= gate_d.reload_cfg;
      abort_op                <= gate_d.abort_op;
      // Select is only honoured once gating allows it
      cs_seen                 <= gate_d.select_ok && !cs_sync_q;
      if (gate_d.reload_cfg)
        reload_seen_q <= 1'b1;
      else if (status_clr)
        reload_seen_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read and response

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_known(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
        case (paddr)
          frs_pkg::EXT_COUNT_OFFSET: prdata <= {16'h0000, ext_count_q};
          frs_pkg::CONTROL_OFFSET:   prdata <= {31'h0, power_good_q};
          frs_pkg::STATUS_OFFSET:    prdata <= {24'h0, reload_seen_q, prog_fail_q, ext_locked_q,
                                                cold_done_q, 1'b0, state_q};
          frs_pkg::EXT_LOCK_OFFSET:  prdata <= {31'h0, ext_locked_q};
          default:                   prdata <= 32'h0000_0000;
        endcase
    end
  end

endmodule

// ### frs_assertions.sv
`timescale 1ns/1ps
module frs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reset_in_n,
  input wire logic system_reset_out_n_o,
  input wire logic system_reset_out_n_oe_n,
  input wire logic int_out_n_oe_n,
  input wire logic accept_cmd,
  input wire logic select_ok,
  input wire logic outputs_en,
  input wire logic reload_cfg,
  input wire logic abort_op,
  input wire logic cs_seen
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////
  // Cycles since the last warm entry, saturating so an old pulse never wraps
  logic [9:0] since_reload_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_reload_q <= 10'h3ff;
    else if (reload_cfg)
      since_reload_q <= 10'h000;
    else if (since_reload_q != 10'h3ff)
      since_reload_q <= since_reload_q + 10'h001;
  ////////////////////////////////
  out_low_only_a: assert property (system_reset_out_n_o == 1'b0)
    else $error("reset out drives high");
  int_floats_a: assert property (int_out_n_oe_n)
    else $error("interrupt pin driven");
  gate_in_reset_a: assert property (
    !system_reset_out_n_oe_n |-> !accept_cmd && !select_ok && !outputs_en)
    else $error("gate open while reset out low");
  pin_blocks_a: assert property (!reset_in_n [*6] |-> !accept_cmd)
    else $error("commands accepted with reset pin low");
  warm_hold_a: assert property (select_ok |-> since_reload_q >= 10'd295)
    else $error("select allowed inside warm reset");
  abort_gate_a: assert property (accept_cmd |-> !abort_op)
    else $error("abort raised while accepting");
  reload_pulse_a: assert property (reload_cfg |=> !reload_cfg)
    else $error("reload longer than one cycle");
  same_gate_a: assert property (select_ok == accept_cmd)
    else $error("select and accept disagree");
  cs_gate_a: assert property ($rose(cs_seen) |-> $past(select_ok))
    else $error("select seen while not selectable");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property ($rose(system_reset_out_n_oe_n));
  cover property (reload_cfg);
  cover property ($rose(cs_seen));
  cover property (pslverr);
endmodule
bind flash_reset_sequencer frs_checker frs_checker_inst (.*);

// ### frs_host_model.sv
`timescale 1ns/1ps
module frs_host_model (
  input  wire logic pclk,
  output logic      reset_in_n,
  output logic      chip_select_n
);
  // Cycles since reset last fell and since it was last low, both saturating
  int unsigned low_age  = 1000;
  int unsigned high_age = 1000;
  logic        prev_rst = 1'b1;
  initial
  begin
    reset_in_n    = 1'b1;
    chip_select_n = 1'b1;
  end
  always @(posedge pclk)
  begin
    prev_rst <= reset_in_n;
    if (prev_rst && !reset_in_n)
      low_age <= 0;
    else if (low_age < 1000)
      low_age <= low_age + 1;
    if (!reset_in_n)
      high_age <= 0;
    else if (high_age < 1000)
      high_age <= high_age + 1;
  end
  // Caller keeps the low time at or above the minimum pulse width
  task automatic pulse_reset(input int cyc);
    @(posedge pclk) reset_in_n <= 1'b0;
    repeat (cyc) @(posedge pclk);
    reset_in_n <= 1'b1;
  endtask
  // Two cycles of gap cover the reset-high to select setup
  task automatic select_pulse();
    while (high_age < 2 || low_age < frs_pkg::WARM_RESET_CYC)
      @(posedge pclk);
    repeat (2) @(posedge pclk);
    chip_select_n <= 1'b0;
    @(posedge pclk);
    chip_select_n <= 1'b1;
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, reset_in_n, chip_select_n, system_reset_out_n_line;
  logic        system_reset_out_n_o, system_reset_out_n_oe_n, int_out_n_oe_n;
  logic        accept_cmd, select_ok, outputs_en, reload_cfg, abort_op, cs_seen;
  int          n_errors = 0;
  int          num_checks = 0;
  int          reload_hits = 0;
  int          cs_hits = 0;
  int          n;

  always #50 pclk = ~pclk;
  // Pull-up gives the released open-drain line its high level
  assign system_reset_out_n_line = system_reset_out_n_oe_n ? 1'b1 : system_reset_out_n_o;
  always @(posedge pclk)
    if (reload_cfg === 1'b1)
      reload_hits++;
  always @(posedge pclk)
    if (cs_seen === 1'b1)
      cs_hits++;

  flash_reset_sequencer flash_reset_sequencer_inst (.*);
  frs_host_model frs_host_model_inst (.*);
  ////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_acc(input int lim);
    n = 0;
    while (accept_cmd !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (accept_cmd !== 1'b1)
      n_errors++;
  endtask

  task automatic chk_state(input frs_pkg::frs_state_e s);
    apb(1'b0, frs_pkg::STATUS_OFFSET, 32'h0);
    chk(32'(rd[2:0]), 32'(s));
  endtask
  ////////////////////////////////
  task automatic t_regs();
    apb(1'b0, frs_pkg::EXT_COUNT_OFFSET, 32'h0);
    chk(rd, 32'(frs_pkg::EXT_COUNT_RESET));
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(err), 32'h1);
    chk_state(frs_pkg::FRS_OFF);
    chk(32'(int_out_n_oe_n), 32'h1);
    $display("t_regs done");
  endtask

  task automatic t_cold();
    // A select pulse inside the power-up wait must be ignored
    apb(1'b1, frs_pkg::CONTROL_OFFSET, 32'h1);
    frs_host_model_inst.select_pulse();
    repeat (frs_pkg::POWER_UP_WAIT_CYC - 10) @(posedge pclk);
    chk(cs_hits, 32'h0);
    chk(32'(accept_cmd), 32'h0);
    chk(32'(system_reset_out_n_line), 32'h0);
    wait_acc(20);
    chk(32'(system_reset_out_n_line), 32'h1);
    chk_state(frs_pkg::FRS_STANDBY);
    chk(32'(rd[frs_pkg::STAT_COLD_DONE_BIT]), 32'h1);
    $display("t_cold done");
  endtask

  task automatic t_warm();
    frs_host_model_inst.pulse_reset(3);
    repeat (frs_pkg::WARM_RESET_CYC - 20) @(posedge pclk);
    chk(32'(select_ok), 32'h0);
    wait_acc(60);
    chk(32'(accept_cmd), 32'h1);
    chk(32'(reload_hits), 32'h1);
    fork
      frs_host_model_inst.pulse_reset(frs_pkg::WARM_RESET_CYC + 200);
      begin
        repeat (frs_pkg::WARM_RESET_CYC + 50) @(posedge pclk);
        chk_state(frs_pkg::FRS_HWRESET);
        chk(32'(abort_op), 32'h1);
        chk(32'(outputs_en), 32'h0);
      end
    join
    wait_acc(20);
    chk(32'(accept_cmd), 32'h1);
    frs_host_model_inst.select_pulse();
    repeat (4) @(posedge pclk);
    chk(cs_hits, 32'h1);
    $display("t_warm done");
  endtask

  task automatic t_cold_pin();
    int len;
    // Reset stays low a full warm duration past the end of the power-up wait
    len = frs_pkg::POWER_UP_WAIT_CYC + frs_pkg::WARM_RESET_CYC + 20;
    apb(1'b1, frs_pkg::CONTROL_OFFSET, 32'h0);
    fork
      frs_host_model_inst.pulse_reset(len);
      begin
        apb(1'b1, frs_pkg::CONTROL_OFFSET, 32'h1);
        repeat (frs_pkg::POWER_UP_WAIT_CYC + 100) @(posedge pclk);
        chk_state(frs_pkg::FRS_HWRESET);
        chk(32'(system_reset_out_n_line), 32'h1);
        chk(32'(accept_cmd), 32'h0);
      end
    join
    wait_acc(20);
    chk(32'(accept_cmd), 32'h1);
    $display("t_cold_pin done");
  endtask

  task automatic t_otp();
    apb(1'b1, frs_pkg::EXT_COUNT_OFFSET, 32'h2);
    apb(1'b1, frs_pkg::EXT_COUNT_OFFSET, 32'h5);
    apb(1'b0, frs_pkg::EXT_COUNT_OFFSET, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, frs_pkg::STATUS_OFFSET, 32'h0);
    chk(32'(rd[frs_pkg::STAT_PROG_FAIL_BIT]), 32'h1);
    $display("t_otp done");
  endtask

  task automatic t_ext();
    int lo;
    lo = frs_pkg::POWER_UP_WAIT_CYC + 3 * frs_pkg::EXTENSION_TICK_CYC;
    apb(1'b1, frs_pkg::CONTROL_OFFSET, 32'h0);
    apb(1'b1, frs_pkg::CONTROL_OFFSET, 32'h1);
    n = 0;
    while (system_reset_out_n_line !== 1'b1 && n < lo + 400)
    begin
      @(posedge pclk);
      n++;
    end
    // Divider is held in cold reset, so release lands near lo; the window still allows one extra tick
    chk(32'(n >= lo - 5 && n <= lo + frs_pkg::EXTENSION_TICK_CYC + 5), 32'h1);
    wait_acc(20);
    $display("t_ext done");
  endtask

  task automatic t_sleep();
    apb(1'b1, frs_pkg::CONTROL_OFFSET, 32'h3);
    repeat (5) @(posedge pclk);
    chk_state(frs_pkg::FRS_SLEEP);
    chk(32'(accept_cmd), 32'h0);
    frs_host_model_inst.pulse_reset(frs_pkg::RESET_PULSE_CYC);
    wait_acc(frs_pkg::DEEP_SLEEP_WAKE_CYC + 400);
    chk(32'(accept_cmd), 32'h1);
    $display("t_sleep done");
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cold();
    t_warm();
    t_cold_pin();
    t_otp();
    t_ext();
    t_sleep();
    end_of_test();
  end

  initial
  begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule
